// >>> hw/ovf_fault_handler.sv
// Input over-voltage fault detection, response and retry control
`timescale 1ns/1ps
`default_nettype none
module ovf_fault_handler #(
    parameter int DELAY_UNIT_NS = ovf_pkg::DELAY_UNIT_NS_DEF
) (
    input  wire logic        sys_clk,
    input  wire logic        rst_b,
    input  wire logic        ce,
    input  wire logic        wr_stb,
    input  wire logic        rd_stb,
    input  wire logic [7:0]  cmd_code,
    input  wire logic [15:0] wr_data,
    input  wire logic [15:0] vin_meas,
    input  wire logic        output_on_cmd,
    input  wire logic        fault_clear,
    output logic [15:0]      rd_data,
    output logic             rd_ack,
    output logic             out_enable,
    output logic             fault_status
);
    localparam int UNIT_CYCLES =
        (DELAY_UNIT_NS + ovf_pkg::CLK_PERIOD_NS - 1) / ovf_pkg::CLK_PERIOD_NS;

    generate
        if (DELAY_UNIT_NS < 1) begin : g_bad_unit
            $error("DELAY_UNIT_NS must be positive");
        end
    endgenerate

    logic [15:0]      thresh_q;
    logic [7:0]       action_q;
    logic [15:0]      rd_data_q;
    logic             rd_ack_q;
    logic             out_q;
    logic             out_d;
    logic             status_q;
    logic [2:0]       tries_q;
    logic [2:0]       tries_d;
    logic             timer_start;
    logic             timer_done;
    ovf_pkg::fstate_t state_q;
    ovf_pkg::fstate_t state_d;

    ////////////////////////////////////////////////////////////////////////////
    // Decode
    wire [1:0] resp  = action_q[ovf_pkg::RESP_HI:ovf_pkg::RESP_LO];
    wire [2:0] retry = action_q[ovf_pkg::RETRY_HI:ovf_pkg::RETRY_LO];
    wire [2:0] dexp  = action_q[ovf_pkg::DELAY_HI:ovf_pkg::DELAY_LO];

    wire fault_now = ovf_pkg::lin_mag(vin_meas) > ovf_pkg::lin_mag(thresh_q);

    wire wr_thresh = wr_stb && (cmd_code == ovf_pkg::CMD_THRESH);
    wire wr_action = wr_stb && (cmd_code == ovf_pkg::CMD_ACTION);
    wire [15:0] rd_sel = (cmd_code == ovf_pkg::CMD_THRESH) ? thresh_q :
                         (cmd_code == ovf_pkg::CMD_ACTION) ? {ovf_pkg::RD_PAD, action_q} :
                         ovf_pkg::RD_NONE;

    wire              retry_go    = (retry != ovf_pkg::RETRY_NONE);
    wire ovf_pkg::fstate_t retry_state = retry_go ? ovf_pkg::ST_WAIT : ovf_pkg::ST_LATCH;
    // endless mode never uses up attempts
    wire [2:0] tries_next = (retry == ovf_pkg::RETRY_ENDLESS) ? tries_q : tries_q - 3'h1;
    wire       tries_gone = (tries_q == 3'h0) && (retry != ovf_pkg::RETRY_ENDLESS);
    wire       try_ok     = out_q && !fault_now;

    ////////////////////////////////////////////////////////////////////////////
    // Response state machine; commanding the output off ends any retry sequence
    always_comb begin
        state_d     = state_q;
        out_d       = out_q;
        tries_d     = tries_q;
        timer_start = 1'b0;
        if (!output_on_cmd) begin
            state_d = ovf_pkg::ST_RUN;
            out_d   = 1'b0;
        end else begin
            unique case (state_q)
                ovf_pkg::ST_RUN: begin
                    out_d = 1'b1;
                    if (fault_now) begin
                        unique case (resp)
                            ovf_pkg::RESP_IGNORE: begin
                                out_d = 1'b1;
                            end
                            ovf_pkg::RESP_HOLD: begin
                                state_d     = ovf_pkg::ST_HOLD;
                                timer_start = 1'b1;
                            end
                            ovf_pkg::RESP_DISABLE: begin
                                out_d       = 1'b0;
                                state_d     = retry_state;
                                tries_d     = retry;
                                timer_start = retry_go;
                            end
                            ovf_pkg::RESP_LATCH: begin
                                out_d   = 1'b0;
                                state_d = ovf_pkg::ST_LATCH;
                            end
                        endcase
                    end
                end
                ovf_pkg::ST_HOLD: begin
                    // act on expiry only if still faulted
                    if (!fault_now) begin
                        state_d = ovf_pkg::ST_RUN;
                    end else if (timer_done) begin
                        out_d       = 1'b0;
                        state_d     = retry_state;
                        tries_d     = retry;
                        timer_start = retry_go;
                    end
                end
                ovf_pkg::ST_WAIT: begin
                    // first attempt one delay after shutdown
                    if (timer_done) begin
                        out_d       = 1'b1;
                        tries_d     = tries_next;
                        timer_start = 1'b1;
                        state_d     = ovf_pkg::ST_TRY;
                    end
                end
                ovf_pkg::ST_TRY: begin
                    if (fault_now) begin
                        out_d = 1'b0;
                    end
                    if (timer_done) begin
                        if (try_ok) begin
                            state_d = ovf_pkg::ST_RUN;
                        end else if (tries_gone) begin
                            out_d   = 1'b0;
                            state_d = ovf_pkg::ST_LATCH;
                        end else begin
                            out_d       = 1'b1;
                            tries_d     = tries_next;
                            timer_start = 1'b1;
                        end
                    end
                end
                ovf_pkg::ST_LATCH: begin
                    out_d = 1'b0;
                    if (fault_clear) begin
                        state_d = ovf_pkg::ST_RUN;
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Reset stands in for bias power removal and clears any latched state
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= ovf_pkg::ST_RUN;
            out_q   <= 1'b0;
            tries_q <= 3'h0;
        end else if (ce) begin
            state_q <= state_d;
            out_q   <= out_d;
            tries_q <= tries_d;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            thresh_q <= ovf_pkg::THRESH_RST;
            action_q <= ovf_pkg::ACTION_RST;
        end else if (ce) begin
            if (wr_thresh) thresh_q <= wr_data;
            if (wr_action) action_q <= wr_data[7:0];
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rd_data_q <= ovf_pkg::RD_NONE;
            rd_ack_q  <= 1'b0;
        end else if (ce) begin
            rd_ack_q <= rd_stb;
            if (rd_stb) rd_data_q <= rd_sel;
        end
    end

    // sticky status, set wins over clear
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            status_q <= 1'b0;
        end else if (ce) begin
            status_q <= fault_now || (status_q && !fault_clear);
        end
    end

    ovf_delay_timer #(
        .UNIT_CYCLES (UNIT_CYCLES)
    ) u_timer (
        .sys_clk   (sys_clk),
        .rst_b     (rst_b),
        .ce        (ce),
        .start     (timer_start),
        .units_exp (dexp),
        .done      (timer_done)
    );

    assign rd_data      = rd_data_q;
    assign rd_ack       = rd_ack_q;
    assign out_enable   = out_q;
    assign fault_status = status_q;

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    sequence s_run_fault;
        ce && output_on_cmd && state_q == ovf_pkg::ST_RUN && fault_now;
    endsequence
    sequence s_try_fail_end;
        ce && output_on_cmd && state_q == ovf_pkg::ST_TRY && timer_done && !try_ok;
    endsequence

    a_thresh_write: assert property (ce && wr_thresh |=> thresh_q == $past(wr_data))
        else $error("threshold write not stored");
    a_action_read: assert property (ce && rd_stb && cmd_code == ovf_pkg::CMD_ACTION
        |=> rd_ack && rd_data == {8'h00, $past(action_q)})
        else $error("response byte read back wrong");
    a_ignore_runs: assert property (s_run_fault and resp == ovf_pkg::RESP_IGNORE
        |=> out_enable ##0 state_q == ovf_pkg::ST_RUN)
        else $error("ignore response interrupted output");
    a_hold_expiry: assert property (ce && output_on_cmd && state_q == ovf_pkg::ST_HOLD
        && fault_now && timer_done |=> !out_enable)
        else $error("output still on after hold delay");
    a_disable_now: assert property (s_run_fault and resp == ovf_pkg::RESP_DISABLE
        |=> !out_enable)
        else $error("disable response left output on");
    a_latch_hold: assert property (s_run_fault and resp == ovf_pkg::RESP_LATCH
        |=> state_q == ovf_pkg::ST_LATCH && !out_enable)
        else $error("latch response did not latch off");
    a_no_retry: assert property (s_run_fault and resp == ovf_pkg::RESP_DISABLE
        and retry == ovf_pkg::RETRY_NONE |=> state_q == ovf_pkg::ST_LATCH)
        else $error("retry 000 did not latch");
    a_tries_spent: assert property (s_try_fail_end and tries_gone
        |=> state_q == ovf_pkg::ST_LATCH && !out_enable)
        else $error("spent retries did not latch off");
    a_retry_start: assert property (ce && output_on_cmd && state_q == ovf_pkg::ST_WAIT
        && timer_done |=> state_q == ovf_pkg::ST_TRY && out_enable)
        else $error("restart attempt not begun at delay end");
    a_endless: assert property (s_try_fail_end and retry == ovf_pkg::RETRY_ENDLESS
        |=> state_q == ovf_pkg::ST_TRY && out_enable)
        else $error("endless retry stopped");
    a_status_set: assert property (ce && fault_now |=> fault_status)
        else $error("fault not flagged");

endmodule
`default_nettype wire

// >>> hw/ovf_pkg.sv
// Constants, types and helpers for the input over-voltage fault handler
package ovf_pkg;

    ////////////////////////////////////////////////////////////////////////////
    localparam logic [7:0]  CMD_THRESH = 8'h55;
    localparam logic [7:0]  CMD_ACTION = 8'h56;
    localparam logic [15:0] THRESH_RST = 16'h7bff;
    localparam logic [7:0]  ACTION_RST = 8'hc0;
    localparam logic [15:0] RD_NONE    = 16'h0000;
    localparam logic [7:0]  RD_PAD     = 8'h00;

    localparam int RESP_HI  = 7;
    localparam int RESP_LO  = 6;
    localparam int RETRY_HI = 5;
    localparam int RETRY_LO = 3;
    localparam int DELAY_HI = 2;
    localparam int DELAY_LO = 0;

    localparam logic [1:0] RESP_IGNORE  = 2'h0;
    localparam logic [1:0] RESP_HOLD    = 2'h1;
    localparam logic [1:0] RESP_DISABLE = 2'h2;
    localparam logic [1:0] RESP_LATCH   = 2'h3;
    localparam logic [2:0] RETRY_NONE    = 3'h0;
    localparam logic [2:0] RETRY_ENDLESS = 3'h7;

    localparam int CLK_PERIOD_NS     = 20;
    localparam int DELAY_UNIT_NS_DEF = 1000;
    localparam int UNIT_CYCLES_DEF   = (DELAY_UNIT_NS_DEF + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0] UNITS_ONE = 8'h01;

    typedef enum logic [2:0] {ST_RUN, ST_HOLD, ST_WAIT, ST_TRY, ST_LATCH} fstate_t;

    // Linear word to unsigned fixed point; exponent+16 is the exponent with its MSB flipped.
    // Negative mantissas count as zero volts.
    function automatic logic [41:0] lin_mag(input logic [15:0] v);
        logic [4:0] sh;
        sh = v[15:11] ^ 5'h10;
        lin_mag = v[10] ? 42'h000_0000_0000 : ({31'h0000_0000, v[10:0]} << sh);
    endfunction

endpackage

// >>> hw/ovf_delay_timer.sv
// Delay timer counting 2^n units of a fixed number of clock cycles
`timescale 1ns/1ps
`default_nettype none
module ovf_delay_timer #(
    parameter int UNIT_CYCLES = ovf_pkg::UNIT_CYCLES_DEF
) (
    input  wire logic       sys_clk,
    input  wire logic       rst_b,
    input  wire logic       ce,
    input  wire logic       start,
    input  wire logic [2:0] units_exp,
    output logic            done
);
    localparam int PW = $clog2(UNIT_CYCLES) + 1;
    localparam logic [PW-1:0] PRE_LAST = PW'(UNIT_CYCLES - 1);

    generate
        if (UNIT_CYCLES < 1) begin : g_bad_unit
            $error("UNIT_CYCLES must be at least one");
        end
    endgenerate

    logic          run_q;
    logic [PW-1:0] pre_q;
    logic [7:0]    left_q;

    wire unit_end  = run_q && (pre_q == PRE_LAST);
    // Done shows in the last cycle so the caller acts on the edge that closes the window;
    // a registered flag would stretch every window, and the restart spacing, by one cycle
    wire last_unit = unit_end && (left_q == ovf_pkg::UNITS_ONE);

    ////////////////////////////////////////////////////////////////////////////
    // A new start restarts the count, so a retry never inherits a stale window
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            run_q  <= 1'b0;
            pre_q  <= '0;
            left_q <= 8'h00;
        end else if (ce) begin
            if (start) begin
                run_q  <= 1'b1;
                pre_q  <= '0;
                left_q <= ovf_pkg::UNITS_ONE << units_exp;
            end else if (unit_end) begin
                pre_q  <= '0;
                left_q <= left_q - ovf_pkg::UNITS_ONE;
                run_q  <= (left_q != ovf_pkg::UNITS_ONE);
            end else if (run_q) begin
                pre_q  <= pre_q + PW'(1);
            end
        end
    end

    assign done = last_unit;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    a_units_decode: assert property (start && ce |=> left_q == (8'h01 << $past(units_exp)))
        else $error("delay units not decoded as two to the n");

endmodule
`default_nettype wire

// >>> dv/pmbus_host_model.sv
// Host controller model that writes and reads the fault handler command registers
`timescale 1ns/1ps
`default_nettype none
module pmbus_host_model (
    input  wire logic        sys_clk,
    output logic             wr_stb,
    output logic             rd_stb,
    output logic [7:0]       cmd_code,
    output logic [15:0]      wr_data,
    input  wire logic [15:0] rd_data,
    input  wire logic        rd_ack
);
    initial begin
        wr_stb   = 1'b0;
        rd_stb   = 1'b0;
        cmd_code = 8'h00;
        wr_data  = 16'h0000;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Idle lines show the inverse of the last value so stale data never matches
    task automatic release_bus();
        wr_stb   = 1'b0;
        rd_stb   = 1'b0;
        cmd_code = ~cmd_code;
        wr_data  = ~wr_data;
    endtask

    task automatic write_reg(input logic [7:0] cmd, input logic [15:0] data);
        @(posedge sys_clk);
        #1;
        wr_stb   = 1'b1;
        cmd_code = cmd;
        wr_data  = data;
        @(posedge sys_clk);
        #1;
        release_bus();
    endtask

    // Request stands until the answer is seen at a rising edge, for at most four edges; a held strobe only re-reads
    task automatic read_reg(input logic [7:0] cmd, output logic [15:0] data, output bit ok);
        ok = 1'b0;
        data = 16'h0000;
        @(posedge sys_clk);
        #1;
        rd_stb   = 1'b1;
        cmd_code = cmd;
        for (int i = 0; i < 4 && !ok; i++) begin
            @(posedge sys_clk);
            if (rd_ack === 1'b1) begin
                data = rd_data;
                ok   = 1'b1;
            end
        end
        #1;
        release_bus();
    endtask
endmodule
`default_nettype wire

// >>> dv/tb.sv
// Self-checking testbench for the input over-voltage fault handler
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam int U = 2;
    localparam logic [15:0] THR = 16'h0100;
    logic        sys_clk, rst_b, ce, output_on_cmd, fault_clear;
    logic        wr_stb, rd_stb, rd_ack, out_enable, fault_status;
    logic [7:0]  cmd_code;
    logic [15:0] wr_data, rd_data, vin_meas;
    int          fails, check_count;

    ovf_fault_handler #(.DELAY_UNIT_NS(40)) dut (.sys_clk(sys_clk), .rst_b(rst_b), .ce(ce),
        .wr_stb(wr_stb), .rd_stb(rd_stb), .cmd_code(cmd_code), .wr_data(wr_data),
        .vin_meas(vin_meas), .output_on_cmd(output_on_cmd), .fault_clear(fault_clear),
        .rd_data(rd_data), .rd_ack(rd_ack), .out_enable(out_enable),
        .fault_status(fault_status));
    pmbus_host_model host (.sys_clk(sys_clk), .wr_stb(wr_stb), .rd_stb(rd_stb),
        .cmd_code(cmd_code), .wr_data(wr_data), .rd_data(rd_data), .rd_ack(rd_ack));

    always #10 sys_clk = ~sys_clk;

    ////////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic rd(input logic [7:0] cmd, input logic [15:0] exp);
        logic [15:0] d;
        bit          ok;
        host.read_reg(cmd, d, ok);
        if (!ok) begin
            fails++;
            $display("[FAIL] read answer expected 1 seen 0");
            tally_and_finish();
        end else begin
            check("read data", d, exp);
        end
    endtask

    // Clears a latched fault and leaves the output running with no fault
    task automatic recover();
        vin_meas = 16'h00ff;
        output_on_cmd = 1'b0;
        tick(2);
        output_on_cmd = 1'b1;
        fault_clear = 1'b1;
        tick(1);
        fault_clear = 1'b0;
        tick(3);
    endtask

    // Cycles from raising the fault until the output drops, bounded
    task automatic off_after(input int limit, output int n);
        vin_meas = 16'h0101;
        n = 0;
        while (out_enable === 1'b1 && n < limit) begin
            tick(1);
            n++;
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        rd(8'h55, 16'h7bff);
        rd(8'h56, 16'h00c0);
        rd(8'h57, 16'h0000);
        host.write_reg(8'h55, THR);
        host.write_reg(8'h56, 16'hff5a);
        host.write_reg(8'h57, 16'h1234);
        ce = 1'b0;
        host.write_reg(8'h55, 16'h0001);
        ce = 1'b1;
        rd(8'h55, THR);
        rd(8'h56, 16'h005a);
    endtask

    task automatic t_modes();
        int n;
        host.write_reg(8'h56, 16'h0000);
        off_after(20, n);
        check("ignore mode output", {15'h0, out_enable}, 16'h0001);
        check("fault status", {15'h0, fault_status}, 16'h0001);
        recover();
        check("status cleared", {15'h0, fault_status}, 16'h0000);
        host.write_reg(8'h56, 16'h00c0);
        off_after(50, n);
        check("latch off delay", 16'(n), 16'h0001);
        vin_meas = 16'h00ff;
        tick(10);
        check("latched output", {15'h0, out_enable}, 16'h0000);
        // Clearing the status alone must release the latch
        fault_clear = 1'b1;
        tick(1);
        fault_clear = 1'b0;
        tick(1);
        check("released output", {15'h0, out_enable}, 16'h0001);
        host.write_reg(8'h56, 16'h0080);
        off_after(50, n);
        check("disable off delay", 16'(n), 16'h0001);
        vin_meas = 16'h00ff;
        tick(3 * U + 10);
        check("no retry output", {15'h0, out_enable}, 16'h0000);
        // Reset stands for bias removal: clears status and latch, registers reload
        rst_b = 1'b0;
        tick(1);
        check("status in reset", {15'h0, fault_status}, 16'h0000);
        rst_b = 1'b1;
        tick(2);
        check("out after reset", {15'h0, out_enable}, 16'h0001);
        rd(ovf_pkg::CMD_ACTION, {ovf_pkg::RD_PAD, ovf_pkg::ACTION_RST});
        host.write_reg(ovf_pkg::CMD_THRESH, THR);
    endtask

    task automatic t_hold();
        int n;
        host.write_reg(8'h56, 16'h0042);
        vin_meas = 16'h0101;
        tick(4 * U - 2);
        vin_meas = 16'h00ff;
        tick(4);
        check("short fault output", {15'h0, out_enable}, 16'h0001);
        for (int d = 0; d < 4; d++) begin
            host.write_reg(8'h56, 16'h0040 | 16'(d));
            off_after(200, n);
            check("hold delay", 16'(n), 16'(((1 << d) * U) + 1));
            recover();
        end
    endtask

    task automatic t_retry();
        int cnt, last, dly;
        logic prev;
        for (int r = 1; r < 8; r++) begin
            dly = (1 << r) * U;
            host.write_reg(8'h56, 16'h0080 | 16'(r << 3) | 16'(r));
            vin_meas = 16'h0101;
            cnt = 0;
            last = 0;
            prev = 1'b1;
            for (int i = 0; i < ((r == 7) ? 10 : r + 2) * dly + 8; i++) begin
                tick(1);
                if (out_enable === 1'b1 && prev !== 1'b1) begin
                    if (cnt > 0) check("attempt spacing", 16'(i - last), 16'(dly));
                    last = i;
                    cnt++;
                end
                prev = out_enable;
            end
            if (r < 7) begin
                check("attempt count", 16'(cnt), 16'(r));
                check("after attempts", {15'h0, out_enable}, 16'h0000);
            end else begin
                check("endless attempts", {15'h0, cnt > 8}, 16'h0001);
                output_on_cmd = 1'b0;
                tick(2);
                check("commanded off", {15'h0, out_enable}, 16'h0000);
            end
            recover();
            check("restart after clear", {15'h0, out_enable}, 16'h0001);
        end
        // A clean attempt hands the output back for good
        host.write_reg(ovf_pkg::CMD_ACTION, 16'h0089);
        vin_meas = 16'h0101;
        tick(2);
        vin_meas = 16'h00ff;
        tick(12 * U);
        check("attempt kept", {15'h0, out_enable}, 16'h0001);
    endtask

    initial begin
        sys_clk = 1'b0;
        rst_b = 1'b0;
        ce = 1'b1;
        output_on_cmd = 1'b1;
        fault_clear = 1'b0;
        vin_meas = 16'h00ff;
        fails = 0;
        check_count = 0;
        repeat (2) @(posedge sys_clk);
        #1;
        check("output in reset", {15'h0, out_enable}, 16'h0000);
        rst_b = 1'b1;
        tick(2);
        t_regs();
        t_modes();
        t_hold();
        t_retry();
        tally_and_finish();
    end
endmodule
`default_nettype wire
